// File: hdl/qrt_cfg.svh
// Timing, threshold and scaling constants for the turn-on control block.
`ifndef QRT_CFG_SVH
`define QRT_CFG_SVH

`define QRT_CLK_PERIOD_NS 10
`define QRT_CLK_KHZ 100000

// Retrigger blanking end points, as times and as feedback levels in mV.
`define QRT_BLANK_MAX_NS 38000
`define QRT_BLANK_MIN_NS 6200
`define QRT_BLANK_MAX_CYC \
  ((`QRT_BLANK_MAX_NS + `QRT_CLK_PERIOD_NS - 1) / `QRT_CLK_PERIOD_NS)
`define QRT_BLANK_MIN_CYC \
  ((`QRT_BLANK_MIN_NS + `QRT_CLK_PERIOD_NS - 1) / `QRT_CLK_PERIOD_NS)
`define QRT_FB_LO_MV 600
`define QRT_FB_HI_MV 1650

// Peak limit scaling: burst reference in mV and feedback divider ratio.
`define QRT_FB_BURST_MV 600
`define QRT_FB_DIV_RATIO 3

// Upper switching frequency; the least period rounds up.
`define QRT_FMAX_KHZ 154
`define QRT_MIN_PERIOD_CYC \
  ((`QRT_CLK_KHZ + `QRT_FMAX_KHZ - 1) / `QRT_FMAX_KHZ)

// Forced turn-on after blanking, valley delay and starter period.
`define QRT_FORCED_NS 6000
`define QRT_FORCED_CYC \
  ((`QRT_FORCED_NS + `QRT_CLK_PERIOD_NS - 1) / `QRT_CLK_PERIOD_NS)
`define QRT_VALLEY_NS 200
`define QRT_VALLEY_CYC \
  ((`QRT_VALLEY_NS + `QRT_CLK_PERIOD_NS - 1) / `QRT_CLK_PERIOD_NS)
`define QRT_STARTER_NS 50000
`define QRT_STARTER_CYC \
  ((`QRT_STARTER_NS + `QRT_CLK_PERIOD_NS - 1) / `QRT_CLK_PERIOD_NS)

`endif

// File: hdl/qrt_limits.sv
// Blanking time and peak current trip computed from the sampled levels.
`timescale 1ns/1ps
`include "qrt_cfg.svh"
module qrt_limits (
  input wire logic clk,
  input wire logic rst,
  input qrt_pkg::qrt_codes_t codes,
  output logic [12:0] blank_cyc,
  output logic trip
);
  import qrt_pkg::*;

  logic [31:0] fb;
  logic [31:0] span;
  logic [31:0] blank;
  logic [31:0] lim_fb;
  logic [31:0] lim;
  logic [31:0] sense;

  always_comb begin
    fb = 32'(codes.feedback_mv);
    // Clamp outside the documented feedback range.
    if (fb < `QRT_FB_LO_MV) begin
      span = 32'h0000_0000;
    end else if (fb > `QRT_FB_HI_MV) begin
      span = `QRT_FB_HI_MV - `QRT_FB_LO_MV;
    end else begin
      span = fb - `QRT_FB_LO_MV;
    end
    blank = `QRT_BLANK_MAX_CYC - span * (`QRT_BLANK_MAX_CYC -
      `QRT_BLANK_MIN_CYC) / (`QRT_FB_HI_MV - `QRT_FB_LO_MV);
    if (fb > `QRT_FB_BURST_MV) begin
      lim_fb = (fb - `QRT_FB_BURST_MV) / `QRT_FB_DIV_RATIO;
    end else begin
      lim_fb = 32'h0000_0000;
    end
    // The lower of the two limits wins.
    if (lim_fb < 32'(codes.cc_limit_mv)) begin
      lim = lim_fb;
    end else begin
      lim = 32'(codes.cc_limit_mv);
    end
    sense = 32'(codes.sense_mv) + 32'(codes.line_offset_mv);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      blank_cyc <= 13'h0000;
      trip <= 1'b0;
    end else begin
      blank_cyc <= blank[12:0];
      trip <= (sense >= lim);
    end
  end
endmodule

// File: hdl/qrt_pkg.sv
// Types shared by the turn-on control block and its helpers.
package qrt_pkg;

  typedef enum logic [1:0] {
    QRT_CHARGE,
    QRT_RUN,
    QRT_STOP
  } qrt_state_t;

  // Comparator outputs, all asynchronous to CLOCK.
  typedef struct packed {
    logic line_above_start;
    logic supply_above_fold;
    logic supply_above_on;
    logic supply_above_off;
    logic demag_above_arm;
    logic demag_above_trig;
    logic fault;
  } qrt_cmp_t;

  // Converter samples in mV, produced on CLOCK.
  typedef struct packed {
    logic [11:0] feedback_mv;
    logic [11:0] sense_mv;
    logic [11:0] cc_limit_mv;
    logic [11:0] line_offset_mv;
  } qrt_codes_t;

endpackage

// File: hdl/qrt_sync.sv
// Two flip-flop synchroniser for the comparator bundle.
`timescale 1ns/1ps
module qrt_sync (
  input wire logic clk,
  input wire logic rst,
  input qrt_pkg::qrt_cmp_t d,
  output qrt_pkg::qrt_cmp_t q
);
  import qrt_pkg::*;

  localparam int W = $bits(qrt_cmp_t);

  logic [W-1:0] d_bits;
  logic [W-1:0] q_bits;

  assign d_bits = d;
  assign q = qrt_cmp_t'(q_bits);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= d_bits[i];
        sync_q <= meta_q;
      end
    end
    assign q_bits[i] = sync_q;
  end
endmodule

// File: hdl/qrt_turn_on_ctrl.sv
// Switching-cycle control of a quasi-resonant flyback controller.
`timescale 1ns/1ps
`include "qrt_cfg.svh"
module qrt_turn_on_ctrl #(
  parameter int STARTER_CYC = `QRT_STARTER_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  input qrt_pkg::qrt_cmp_t CMP,
  input qrt_pkg::qrt_codes_t CODES,
  output logic GATE_DRIVE,
  output logic CHARGE_FULL,
  output logic CHARGE_FOLD,
  output logic REGULATING,
  output logic STARTER_ACTIVE
);
  import qrt_pkg::*;

  localparam int PER_M1 = `QRT_MIN_PERIOD_CYC - 1;
  localparam int VALLEY_M1 = `QRT_VALLEY_CYC - 1;
  localparam int FORCED = `QRT_FORCED_CYC;
  localparam logic [12:0] CNT_MAX = 13'h1FFF;

  qrt_cmp_t cmp_s;
  logic [12:0] blank_cyc;
  logic trip;

  qrt_state_t st_q;
  qrt_state_t st_d;
  logic gate_q;
  logic arm_q;
  logic locked_q;
  logic pend_q;
  logic [4:0] dly_q;
  logic [12:0] cnt_q;
  logic chg_full_q;
  logic chg_fold_q;
  logic arm_prev_q;
  logic trig_prev_q;

  logic keep_run;
  logic arm_rise;
  logic trig_fall;
  logic blank_done;
  logic period_ok;
  logic valley_start;
  logic valley_done;
  logic forced_on;
  logic starter_on;
  logic turn_on;
  logic [13:0] forced_at;

  // Every comparator passes two flip-flops before any logic sees it.
  qrt_sync u_sync (
    .clk(CLOCK),
    .rst(RST),
    .d(CMP),
    .q(cmp_s)
  );

  qrt_limits u_limits (
    .clk(CLOCK),
    .rst(RST),
    .codes(CODES),
    .blank_cyc(blank_cyc),
    .trip(trip)
  );

  // Supervisor: charging, regulating, stopped.
  assign keep_run = (st_q == QRT_RUN) && cmp_s.line_above_start &&
    cmp_s.supply_above_off && !cmp_s.fault;

  always_comb begin
    st_d = st_q;
    case (st_q)
      QRT_CHARGE: begin
        if (cmp_s.supply_above_on && cmp_s.line_above_start &&
            !cmp_s.fault) begin
          st_d = QRT_RUN;
        end
      end
      QRT_RUN: begin
        if (!keep_run) begin
          st_d = QRT_STOP;
        end
      end
      QRT_STOP: begin
        // Waiting for the supply to collapse keeps a lost line from
        // restarting the converter on the charge left in the capacitor.
        if (!cmp_s.supply_above_off) begin
          st_d = QRT_CHARGE;
        end
      end
      default: begin
        st_d = QRT_CHARGE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= QRT_CHARGE;
    end else begin
      st_q <= st_d;
    end
  end

  // The charger runs only in the charging state and with the line present.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      chg_full_q <= 1'b0;
      chg_fold_q <= 1'b0;
    end else begin
      chg_full_q <= (st_d == QRT_CHARGE) && cmp_s.line_above_start &&
        cmp_s.supply_above_fold;
      chg_fold_q <= (st_d == QRT_CHARGE) && cmp_s.line_above_start &&
        !cmp_s.supply_above_fold;
    end
  end

  // Edge detection works on synchronised levels only.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arm_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      arm_prev_q <= cmp_s.demag_above_arm;
      trig_prev_q <= cmp_s.demag_above_trig;
    end
  end

  assign arm_rise = cmp_s.demag_above_arm && !arm_prev_q;
  assign trig_fall = trig_prev_q && !cmp_s.demag_above_trig;

  // Cycles since the last turn-on, saturating so a long idle never wraps.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cnt_q <= CNT_MAX;
    end else if (turn_on) begin
      cnt_q <= 13'h0000;
    end else if (cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + 13'h0001;
    end
  end

  assign blank_done = (cnt_q >= blank_cyc);
  assign period_ok = (cnt_q >= 13'(PER_M1));
  assign forced_at = {1'b0, blank_cyc} + 14'(FORCED);

  // Arming: cleared at every turn-on, so each cycle needs a fresh arm.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arm_q <= 1'b0;
    end else if (turn_on) begin
      arm_q <= 1'b0;
    end else if (arm_rise) begin
      arm_q <= 1'b1;
    end
  end

  // An edge starts the valley delay only once blanking has expired, so
  // earlier ringing valleys are skipped whole.
  assign valley_start = keep_run && !gate_q && !pend_q && arm_q &&
    trig_fall && blank_done;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pend_q <= 1'b0;
      dly_q <= 5'h00;
    end else if (!keep_run || turn_on) begin
      pend_q <= 1'b0;
      dly_q <= 5'h00;
    end else if (valley_start) begin
      pend_q <= 1'b1;
      dly_q <= 5'h00;
    end else if (pend_q && dly_q != 5'(VALLEY_M1)) begin
      dly_q <= dly_q + 5'h01;
    end
  end

  assign valley_done = pend_q && (dly_q == 5'(VALLEY_M1));

  // Forced turn-on covers a lost edge once demag has locked the loop.
  assign forced_on = locked_q && !pend_q &&
    ({1'b0, cnt_q} >= forced_at);

  // The starter paces cycles while demag is too weak to arm, including
  // low output voltage under current regulation.
  assign starter_on = !locked_q && !pend_q &&
    (32'(cnt_q) >= STARTER_CYC);

  assign turn_on = keep_run && !gate_q && period_ok &&
    (valley_done || forced_on || starter_on);

  // Lock follows whether the cycle just ended was armed.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      locked_q <= 1'b0;
    end else if (st_q != QRT_RUN) begin
      locked_q <= 1'b0;
    end else if (turn_on) begin
      locked_q <= arm_q;
    end
  end

  // Gate: set by turn-on, cleared by the peak trip or by leaving regulation.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      gate_q <= 1'b0;
    end else if (!keep_run) begin
      gate_q <= 1'b0;
    end else if (turn_on) begin
      gate_q <= 1'b1;
    end else if (gate_q && trip) begin
      gate_q <= 1'b0;
    end
  end

  assign GATE_DRIVE = gate_q;
  assign CHARGE_FULL = chg_full_q;
  assign CHARGE_FOLD = chg_fold_q;
  assign REGULATING = (st_q == QRT_RUN);
  assign STARTER_ACTIVE = (st_q == QRT_RUN) && !locked_q;

  // A valley delay that ends before the least period has passed waits for
  // it, which can add up to nine cycles to the twenty of the delay.
  localparam int VALLEY_WAIT = 32;
  localparam logic [12:0] BLANK_LO = 13'(`QRT_BLANK_MIN_CYC);
  localparam logic [12:0] BLANK_HI = 13'(`QRT_BLANK_MAX_CYC);

  AST_CHARGE_LINE: assert property (@(posedge CLOCK) disable iff (RST)
    (chg_full_q || chg_fold_q) |-> $past(cmp_s.line_above_start))
    else $error("Charger enabled without line above start.");

  AST_CHARGE_FOLD: assert property (@(posedge CLOCK) disable iff (RST)
    chg_fold_q |-> !$past(cmp_s.supply_above_fold) && !chg_full_q)
    else $error("Fold current used above the fold level.");

  AST_RUN_NO_CHARGE: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q == QRT_RUN) |-> !chg_full_q && !chg_fold_q)
    else $error("Charger still on while regulating.");

  AST_LINE_LOSS: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q == QRT_RUN && !cmp_s.line_above_start) |=>
      (st_q == QRT_STOP) && !gate_q)
    else $error("Regulation kept after line loss.");

  AST_ARMED_ONLY: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(pend_q) |-> $past(arm_q) && $past(trig_fall))
    else $error("Valley delay started without arming.");

  AST_BLANK_IGNORE: assert property (@(posedge CLOCK) disable iff (RST)
    (trig_fall && cnt_q < blank_cyc && !pend_q) |=> !pend_q)
    else $error("Edge inside blanking was accepted.");

  AST_FMAX: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(gate_q) |-> $past(cnt_q) >= 13'(PER_M1))
    else $error("Switching period shorter than the least period.");

  AST_VALLEY_DELAY: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(pend_q) |-> ##[1:VALLEY_WAIT] (gate_q || st_q != QRT_RUN))
    else $error("Valley delay did not end in a turn-on.");

  AST_FORCED: assert property (@(posedge CLOCK) disable iff (RST)
    (keep_run && locked_q && !gate_q && !pend_q && period_ok &&
     {1'b0, cnt_q} >= forced_at && $stable(st_q)) |=>
      (gate_q || st_q != QRT_RUN))
    else $error("Forced turn-on missing.");

  AST_STARTER: assert property (@(posedge CLOCK) disable iff (RST)
    (keep_run && !locked_q && !gate_q && !pend_q && period_ok &&
     32'(cnt_q) >= STARTER_CYC) |=> (gate_q || st_q != QRT_RUN))
    else $error("Starter did not start a cycle.");

  AST_PEAK_OFF: assert property (@(posedge CLOCK) disable iff (RST)
    (gate_q && trip) |=> !gate_q)
    else $error("Gate stayed on past the peak limit.");

  AST_LOCKOUT_LOW: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q != QRT_RUN) |=> !gate_q)
    else $error("Gate driven outside regulation.");

  AST_FAULT_STOP: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q == QRT_RUN && (cmp_s.fault || !cmp_s.supply_above_off)) |=>
      (st_q == QRT_STOP) ##1 !gate_q)
    else $error("Fault did not stop switching.");

  AST_BLANK_AFTER_ON: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(gate_q) |=> !pend_q [*8])
    else $error("Trigger not blanked after turn-on.");

  AST_VALLEY_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(pend_q) |-> !gate_q [*8])
    else $error("Gate rose inside the valley delay.");

  AST_UNARMED: assert property (@(posedge CLOCK) disable iff (RST)
    (trig_fall && !arm_q && !pend_q) |=> !pend_q)
    else $error("Unarmed falling edge started a valley delay.");

  AST_ARM_CLEAR: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(gate_q) |-> !arm_q)
    else $error("Trigger still armed after turn-on.");

  AST_CNT_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(gate_q) |-> (cnt_q == 13'h0000))
    else $error("Cycle counter not restarted at turn-on.");

  AST_LOCK_ARM: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(gate_q) |-> (locked_q == $past(arm_q)))
    else $error("Lock does not follow the arming of the cycle.");

  AST_LINE_CHG: assert property (@(posedge CLOCK) disable iff (RST)
    !cmp_s.line_above_start |=> !chg_full_q && !chg_fold_q)
    else $error("Charger left on without the line.");

  AST_STOP_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q == QRT_STOP && cmp_s.supply_above_off) |=> (st_q == QRT_STOP))
    else $error("Stopped converter restarted on the held supply.");

  AST_BLANK_RANGE: assert property (@(posedge CLOCK) disable iff (RST)
    (st_q == QRT_RUN) |-> (blank_cyc >= BLANK_LO) && (blank_cyc <= BLANK_HI))
    else $error("Blanking time outside its end points.");

  AST_PEAK_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
    (gate_q && !trip && keep_run) |=> gate_q)
    else $error("Gate turned off before the peak limit.");

endmodule

// File: tb/qrt_plant.sv
// Behavioural switch and auxiliary winding seen through the comparators.
`timescale 1ns/1ps
module qrt_plant #(
  parameter int DEMAG_CYC = 100,
  parameter int RING_CYC = 40
) (
  input wire logic clk,
  input wire logic gate,
  input wire logic aux_en,
  input wire logic [7:0] rings,
  output logic demag_hi,
  output logic [11:0] sense_mv
);
  logic [15:0] off_q = 16'hFFFF;
  logic [11:0] sense_q = 12'h000;
  int rt;
  assign sense_mv = sense_q;
  // Sensed current ramps one mV a cycle while the switch conducts.
  always_ff @(posedge clk) begin
    if (gate) begin
      off_q <= 16'h0000;
      sense_q <= sense_q + 12'h001;
    end else begin
      sense_q <= 12'h000;
      off_q <= (off_q == 16'hFFFF) ? off_q : off_q + 16'h0001;
    end
  end
  // Once the ringing count runs out the winding stays low, so only the
  // forced turn-on can start the next cycle.
  always_comb begin
    rt = int'(off_q) - DEMAG_CYC;
    demag_hi = aux_en && !gate && (rt < 0 || (rt < int'(rings) * RING_CYC
      && (rt % RING_CYC) >= RING_CYC / 2));
  end
endmodule

// File: tb/qrt_turn_on_ctrl_tb.sv
// Self-checking bench for the quasi-resonant turn-on control block.
`timescale 1ns/1ps
module qrt_turn_on_ctrl_tb;
  import qrt_pkg::*;
  localparam int START_CYC = 700;
  localparam int LIM = 12000;
  typedef struct {
    int fb;
    int cc;
    int ofs;
    int trip;
    int minp;
  } qrt_row_t;
  // Feedback, current limit, line offset, sense at trip, least period.
  qrt_row_t rows [5] = '{
    '{660, 500, 0, 20, 3619},
    '{1125, 500, 0, 175, 2210},
    '{1125, 100, 0, 100, 2210},
    '{1650, 900, 50, 300, 650},
    '{2000, 300, 0, 300, 650}
  };
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic line_b = 1'b0;
  logic fold_b = 1'b0;
  logic on_b = 1'b0;
  logic off_b = 1'b0;
  logic flt_b = 1'b0;
  logic aux_b = 1'b0;
  logic [7:0] rings_b = 8'h00;
  logic [11:0] fb_b = 12'h000;
  logic [11:0] cc_b = 12'h000;
  logic [11:0] ofs_b = 12'h000;
  logic demag_w;
  logic [11:0] sense_w;
  qrt_cmp_t cmp_w;
  qrt_codes_t codes_w;
  logic gate_w;
  logic full_w;
  logic fold_w;
  logic reg_w;
  logic start_w;
  int bad_count = 0;
  int checks_done = 0;
  int a;
  int b;
  // The winding crosses both demagnetisation levels together.
  assign cmp_w = {line_b, fold_b, on_b, off_b, demag_w, demag_w, flt_b};
  assign codes_w = {fb_b, sense_w, cc_b, ofs_b};

  qrt_turn_on_ctrl #(
    .STARTER_CYC(START_CYC)
  ) DUT (
    .CLOCK(CLOCK),
    .RST(RST),
    .CMP(cmp_w),
    .CODES(codes_w),
    .GATE_DRIVE(gate_w),
    .CHARGE_FULL(full_w),
    .CHARGE_FOLD(fold_w),
    .REGULATING(reg_w),
    .STARTER_ACTIVE(start_w)
  );

  qrt_plant plant (
    .clk(CLOCK),
    .gate(gate_w),
    .aux_en(aux_b),
    .rings(rings_b),
    .demag_hi(demag_w),
    .sense_mv(sense_w)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  task automatic wait_gate(input logic lvl, output int n);
    n = 0;
    while (gate_w !== lvl) begin
      tick(1);
      n++;
      if (n > LIM) begin
        bad_count++;
        $display("BAD %0t gate wait timed out", $time);
        tally_and_finish();
      end
    end
  endtask

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end

  initial begin
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge CLOCK);
      line_b <= i[1];
      fold_b <= i[0];
      tick(4);
      check(full_w, i[1] & i[0]);
      check(fold_w, i[1] & ~i[0]);
      check(gate_w, 1'b0);
    end
    $display("charger test done");
    @(posedge CLOCK);
    fb_b <= 12'h465;
    cc_b <= 12'h064;
    on_b <= 1'b1;
    off_b <= 1'b1;
    tick(5);
    check(reg_w, 1'b1);
    check(full_w | fold_w, 1'b0);
    wait_gate(1'b1, a);
    wait_gate(1'b0, a);
    check(start_w, 1'b1);
    wait_gate(1'b1, b);
    check(a + b >= START_CYC - 2 && a + b <= START_CYC + 8, 1'b1);
    @(posedge CLOCK);
    aux_b <= 1'b1;
    rings_b <= 8'hFF;
    wait_gate(1'b0, a);
    wait_gate(1'b1, a);
    wait_gate(1'b0, a);
    check(start_w, 1'b0);
    $display("starter test done");
    // The row is set one cycle early, so that cycle is skipped.
    for (int i = 0; i < 5; i++) begin
      @(posedge CLOCK);
      fb_b <= 12'(rows[i].fb);
      cc_b <= 12'(rows[i].cc);
      ofs_b <= 12'(rows[i].ofs);
      wait_gate(1'b1, a);
      wait_gate(1'b0, a);
      wait_gate(1'b1, a);
      wait_gate(1'b0, a);
      check(sense_w >= rows[i].trip && sense_w <= rows[i].trip + 4,
        1'b1);
      wait_gate(1'b1, b);
      check(a + b >= rows[i].minp && a + b <= rows[i].minp + 70,
        1'b1);
      $display("row %0d done", i);
    end
    @(posedge CLOCK);
    rings_b <= 8'h00;
    wait_gate(1'b0, a);
    wait_gate(1'b1, b);
    check(a + b >= 1218 && a + b <= 1226, 1'b1);
    $display("forced turn-on test done");
    @(posedge CLOCK);
    line_b <= 1'b0;
    tick(5);
    check(reg_w | gate_w, 1'b0);
    @(posedge CLOCK);
    line_b <= 1'b1;
    tick(5);
    check(reg_w | full_w, 1'b0);
    @(posedge CLOCK);
    on_b <= 1'b0;
    off_b <= 1'b0;
    tick(5);
    check(full_w, 1'b1);
    @(posedge CLOCK);
    on_b <= 1'b1;
    off_b <= 1'b1;
    tick(5);
    check(reg_w, 1'b1);
    @(posedge CLOCK);
    flt_b <= 1'b1;
    tick(5);
    check(reg_w | gate_w, 1'b0);
    $display("stop test done");
    @(posedge CLOCK);
    RST <= 1'b1;
    flt_b <= 1'b0;
    tick(3);
    check(gate_w | full_w | fold_w | reg_w | start_w, 1'b0);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
